// File: hw/adc_seq_pkg.sv
// Sequencer constants and carrier types
package adc_seq_pkg;
    // Register byte offsets
    localparam logic [15:0] OFS_CTRL      = 16'h7008;
    localparam logic [15:0] OFS_RANGE_LO  = 16'h700C;
    localparam logic [15:0] OFS_RANGE_HI  = 16'h7010;
    localparam logic [15:0] OFS_TIMER     = 16'h7014;
    localparam logic [15:0] OFS_THRESH    = 16'h7018;
    localparam logic [15:0] OFS_START     = 16'h701C;
    localparam logic [15:0] OFS_FIFO      = 16'h7020;
    localparam logic [15:0] OFS_GAIN_A    = 16'h7024;
    localparam logic [15:0] OFS_GAIN_B    = 16'h7028;
    localparam logic [15:0] OFS_OFFSET_A  = 16'h702C;
    localparam logic [15:0] OFS_OFFSET_B  = 16'h7030;
    // Control register fields
    localparam int          CTRL_MODE_LSB = 0;
    localparam int          CTRL_IRQ_EN   = 4;
    localparam int          CTRL_TRIG_OUT = 5;
    localparam int          CTRL_EMPTY    = 8;
    localparam int          CTRL_FULL     = 9;
    localparam int          CTRL_CNT_LSB  = 16;
    localparam int          START_BIT     = 0;
    localparam logic [1:0]  MODE_SINGLE   = 2'h1;
    localparam logic [1:0]  MODE_CONT     = 2'h2;
    // Data word and channel layout
    localparam int          SAMPLE_W      = 16;
    localparam int          TAG_W         = 4;
    localparam int          TAG_LSB       = 16;
    localparam int          CHAN_PER_ADC  = 8;
    localparam int          RANGE_W       = 3;
    localparam int          RANGE_REG_W   = 24;
    localparam logic [2:0]  RANGE_OFF     = 3'h0;
    localparam int          FIFO_DEPTH    = 1026;
    localparam int          THRESH_W      = 10;
    localparam int          GAIN_FRAC     = 15;
    // Reset values
    localparam logic [15:0] GAIN_UNITY    = 16'h8000;
    localparam logic [15:0] OFFSET_RESET  = 16'h0000;
    localparam logic [9:0]  THRESH_RESET  = 10'h3FF;
    localparam logic [31:0] TIMER_RESET   = 32'h0000_0000;
    localparam logic [23:0] RANGE_RESET   = 24'h00_0000;
    // Timer units of 1/2.5 MHz: 25 per clock, 16 per reference tick
    localparam int          CLK_HZ        = 40_000_000;
    localparam int          TIMER_REF_HZ  = 62_500_000;
    localparam int          RATIO_UNIT_HZ = 2_500_000;
    localparam logic [5:0]  ACC_ADD       = 6'(CLK_HZ / RATIO_UNIT_HZ);
    localparam logic [5:0]  ACC_WRAP      = 6'(TIMER_REF_HZ / RATIO_UNIT_HZ);
    localparam logic [31:0] TIMER_MIN     = 32'd78;

    typedef struct packed {
        logic [TAG_W-1:0]    tag;
        logic [SAMPLE_W-1:0] sample;
    } fifo_entry_t;

    typedef struct packed {
        logic [SAMPLE_W-1:0] gain;
        logic [SAMPLE_W-1:0] offset;
    } correction_t;
endpackage : adc_seq_pkg

// File: hw/adc_sequencer_tagged_fifo.sv
// Two-converter sequencer with corrected, tagged sample FIFO
// How it works
// RL1: Sample low, tag above, upper bits zero
// RL2: Gain multiply, then offset add, before store
// RL3: Reset gives unity gain, zero offset
// RL4: Each sample tagged with its channel
// RL5: Control register shows FIFO empty
// RL6: Full FIFO drops samples until read
// RL7: Single mode starts on software or trigger
// RL8: Converter A does 0-7, B 8-15
// RL9: Only valid-range channels get stored
// RL10: Single mode idles after one cycle
// RL11: Mode bits 01 single, 10 continuous
// RL12: Timer needed in single mode too
// RL13: Trigger pin can drive out
// RL14: Continuous mode repeats at timer rate
// RL15: Converters step one channel together
// RL16: Continuous starts on first start event
// RL17: Spacing is timer value plus one, with timer values below 78 taken as 78
// RL18: Start bit one starts conversions
// RL19: Range code 000 disables channel
// RL20: Interrupt while count at or above threshold
// RL21: FIFO read pops oldest entry
`timescale 1ns/1ps
`default_nettype none
module adc_sequencer_tagged_fifo
    import adc_seq_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    // Clock, reset, clock enable
    input  wire logic                i_clk,
    input  wire logic                i_rst_b,
    input  wire logic                i_ce,
    // Register port
    input  wire logic                i_reg_wr,
    input  wire logic                i_reg_rd,
    input  wire logic [15:0]         i_reg_addr,
    input  wire logic [31:0]         i_reg_wdata,
    output logic [31:0]              o_reg_rdata,
    // Converter pair
    output logic                     o_conv_start,
    output logic [2:0]               o_conv_chan,
    input  wire logic                i_adc_valid,
    input  wire logic [SAMPLE_W-1:0] i_adc_data_a,
    input  wire logic [SAMPLE_W-1:0] i_adc_data_b,
    // External trigger pin
    input  wire logic                i_trig,
    output logic                     o_trig,
    output logic                     o_trig_oe_b,
    // Threshold request
    output logic                     o_irq
);
    localparam int CW = $clog2(DEPTH + 1);

    initial begin
        if (DEPTH < 1024 || CW > 16) begin
            $error("depth too small");
        end
    end

    typedef enum logic [2:0] {
        S_IDLE, S_CONV, S_WAIT, S_PUSH_A, S_PUSH_B, S_GAP
    } seq_state_t;

    // Registers
    logic [1:0]             mode_reg;
    logic                   irq_en_reg;
    logic                   trig_out_reg;
    logic [RANGE_REG_W-1:0] range_lo_reg;
    logic [RANGE_REG_W-1:0] range_hi_reg;
    logic [31:0]            timer_reg;
    logic [THRESH_W-1:0]    thresh_reg;
    correction_t            corr_a_reg;
    correction_t            corr_b_reg;
    // Sequencer state
    seq_state_t             state_reg;
    logic [2:0]             step_reg;
    logic [SAMPLE_W-1:0]    res_a_reg;
    logic [SAMPLE_W-1:0]    res_b_reg;
    logic [37:0]            tick_cnt_reg;
    logic                   timer_done_reg;
    logic [2:0]             trig_sync_reg;
    // Combinational
    logic                   sw_start;
    logic                   trig_rise;
    logic                   start_evt;
    logic                   fifo_rd;
    logic                   push;
    fifo_entry_t            push_data;
    fifo_entry_t            head;
    logic                   empty;
    logic                   full;
    logic [CW-1:0]          count;
    logic [31:0]            limit;
    logic [37:0]            due;
    logic                   cycle_last;

    function automatic logic chan_on(input logic [RANGE_REG_W-1:0] r, input logic [2:0] i);
        return r[i*RANGE_W +: RANGE_W] != RANGE_OFF;  // see RL19
    endfunction : chan_on

    function automatic logic [SAMPLE_W-1:0] correct(input logic [SAMPLE_W-1:0] d,
                                                     input correction_t c);
        logic [31:0] prod;
        prod = d * c.gain;                                             // see RL2
        return SAMPLE_W'(prod[GAIN_FRAC +: SAMPLE_W] + c.offset);      // see RL2
    endfunction : correct

    function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
        return a == ofs;
    endfunction : hit

    assign sw_start   = i_reg_wr && hit(i_reg_addr, OFS_START) && i_reg_wdata[START_BIT];  // see RL18
    assign trig_rise  = trig_sync_reg[1] && !trig_sync_reg[2] && !trig_out_reg;
    assign start_evt  = sw_start || trig_rise;
    assign fifo_rd    = i_reg_rd && hit(i_reg_addr, OFS_FIFO);
    assign limit      = (timer_reg < TIMER_MIN) ? TIMER_MIN : timer_reg;  // see RL17
    // Reference is faster than the clock, so time is summed, not ticks
    assign due        = 38'(({6'h00, limit} + 38'h1) * 38'(ACC_ADD));
    assign cycle_last = step_reg == 3'(CHAN_PER_ADC - 1);

    // One tagged push per cycle
    always_comb begin
        push             = 1'b0;
        push_data.sample = res_a_reg;
        push_data.tag    = {1'b0, step_reg};                           // see RL4
        if (state_reg == S_PUSH_A) begin
            push = chan_on(range_lo_reg, step_reg);                    // see RL9
        end else if (state_reg == S_PUSH_B) begin
            push             = chan_on(range_hi_reg, step_reg);        // see RL9
            push_data.sample = res_b_reg;
            push_data.tag    = {1'b1, step_reg};                       // see RL8
        end
    end

    sample_fifo #(
        .DEPTH (DEPTH),
        .CW    (CW)
    ) u_fifo (
        .i_clk       (i_clk),
        .i_rst_b     (i_rst_b),
        .i_ce        (i_ce),
        .i_push      (push),                                           // see RL6
        .i_push_data (push_data),
        .i_pop       (fifo_rd),                                        // see RL21
        .o_head      (head),
        .o_empty     (empty),
        .o_full      (full),
        .o_count     (count)
    );

    // Register writes
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            mode_reg     <= 2'h0;
            irq_en_reg   <= 1'b0;
            trig_out_reg <= 1'b0;
            range_lo_reg <= RANGE_RESET;
            range_hi_reg <= RANGE_RESET;
            timer_reg    <= TIMER_RESET;
            thresh_reg   <= THRESH_RESET;
            corr_a_reg   <= '{gain: GAIN_UNITY, offset: OFFSET_RESET};  // see RL3
            corr_b_reg   <= '{gain: GAIN_UNITY, offset: OFFSET_RESET};  // see RL3
        end else if (i_ce && i_reg_wr) begin
            unique case (i_reg_addr)
                OFS_CTRL: begin
                    mode_reg     <= i_reg_wdata[CTRL_MODE_LSB +: 2];   // see RL11
                    irq_en_reg   <= i_reg_wdata[CTRL_IRQ_EN];
                    trig_out_reg <= i_reg_wdata[CTRL_TRIG_OUT];        // see RL13
                end
                OFS_RANGE_LO: range_lo_reg      <= i_reg_wdata[RANGE_REG_W-1:0];
                OFS_RANGE_HI: range_hi_reg      <= i_reg_wdata[RANGE_REG_W-1:0];
                OFS_TIMER:    timer_reg         <= i_reg_wdata;
                OFS_THRESH:   thresh_reg        <= i_reg_wdata[THRESH_W-1:0];
                OFS_GAIN_A:   corr_a_reg.gain   <= i_reg_wdata[SAMPLE_W-1:0];
                OFS_GAIN_B:   corr_b_reg.gain   <= i_reg_wdata[SAMPLE_W-1:0];
                OFS_OFFSET_A: corr_a_reg.offset <= i_reg_wdata[SAMPLE_W-1:0];
                OFS_OFFSET_B: corr_b_reg.offset <= i_reg_wdata[SAMPLE_W-1:0];
                default: ;
            endcase
        end
    end

    // Register reads, one cycle after the strobe
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_reg_rdata <= 32'h0000_0000;
        end else if (i_ce && i_reg_rd) begin
            o_reg_rdata <= 32'h0000_0000;
            unique case (i_reg_addr)
                OFS_CTRL: begin
                    o_reg_rdata[CTRL_MODE_LSB +: 2]  <= mode_reg;
                    o_reg_rdata[CTRL_IRQ_EN]         <= irq_en_reg;
                    o_reg_rdata[CTRL_TRIG_OUT]       <= trig_out_reg;
                    o_reg_rdata[CTRL_EMPTY]          <= empty;             // see RL5
                    o_reg_rdata[CTRL_FULL]           <= full;
                    o_reg_rdata[CTRL_CNT_LSB +: 16]  <= 16'(count);
                end
                OFS_RANGE_LO: o_reg_rdata[RANGE_REG_W-1:0] <= range_lo_reg;
                OFS_RANGE_HI: o_reg_rdata[RANGE_REG_W-1:0] <= range_hi_reg;
                OFS_TIMER:    o_reg_rdata                  <= timer_reg;
                OFS_THRESH:   o_reg_rdata[THRESH_W-1:0]    <= thresh_reg;
                OFS_FIFO: begin
                    if (!empty) begin
                        o_reg_rdata[SAMPLE_W-1:0]       <= head.sample;  // see RL1
                        o_reg_rdata[TAG_LSB +: TAG_W]   <= head.tag;     // see RL1
                    end
                end
                OFS_GAIN_A:   o_reg_rdata[SAMPLE_W-1:0]    <= corr_a_reg.gain;
                OFS_GAIN_B:   o_reg_rdata[SAMPLE_W-1:0]    <= corr_b_reg.gain;
                OFS_OFFSET_A: o_reg_rdata[SAMPLE_W-1:0]    <= corr_a_reg.offset;
                OFS_OFFSET_B: o_reg_rdata[SAMPLE_W-1:0]    <= corr_b_reg.offset;
                default: ;
            endcase
        end
    end

    // Trigger pin synchroniser; stage 0 feeds stage 1 only
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            trig_sync_reg <= 3'h0;
        end else if (i_ce) begin
            trig_sync_reg <= {trig_sync_reg[1:0], i_trig};
        end
    end

    // Step timer, restarted at every conversion start
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tick_cnt_reg   <= 38'h0;
            timer_done_reg <= 1'b0;
        end else if (i_ce) begin
            if (state_reg == S_CONV) begin
                // Start cycle counts
                tick_cnt_reg   <= 38'(ACC_WRAP);
                timer_done_reg <= 1'b0;
            end else if (!timer_done_reg) begin
                tick_cnt_reg <= tick_cnt_reg + 38'(ACC_WRAP);
                if (tick_cnt_reg + 38'(ACC_WRAP) >= due) begin
                    timer_done_reg <= 1'b1;                            // see RL17
                end
            end
        end
    end

    // Step sequencer
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_reg <= S_IDLE;
            step_reg  <= 3'h0;
            res_a_reg <= 16'h0000;
            res_b_reg <= 16'h0000;
        end else if (i_ce) begin
            unique case (state_reg)
                S_IDLE: begin
                    step_reg <= 3'h0;
                    if (start_evt && (mode_reg == MODE_SINGLE || mode_reg == MODE_CONT)) begin
                        state_reg <= S_CONV;                           // see RL7, RL16
                    end
                end
                S_CONV: state_reg <= S_WAIT;                           // see RL15
                S_WAIT: begin
                    if (i_adc_valid) begin
                        res_a_reg <= correct(i_adc_data_a, corr_a_reg);
                        res_b_reg <= correct(i_adc_data_b, corr_b_reg);
                        state_reg <= S_PUSH_A;
                    end
                end
                S_PUSH_A: state_reg <= S_PUSH_B;
                S_PUSH_B: begin
                    step_reg <= 3'(step_reg + 1'b1);
                    if (cycle_last && mode_reg != MODE_CONT) begin
                        state_reg <= S_IDLE;                           // see RL10
                    end else begin
                        state_reg <= S_GAP;                            // see RL14
                    end
                end
                S_GAP: begin
                    if (timer_done_reg) begin
                        state_reg <= S_CONV;                           // see RL12
                    end
                end
            endcase
        end
    end

    assign o_conv_start = i_ce && (state_reg == S_CONV);
    assign o_conv_chan  = step_reg;
    assign o_trig       = trig_out_reg && o_conv_start
                          && step_reg == 3'h0;                         // see RL13
    assign o_trig_oe_b  = !trig_out_reg;
    assign o_irq        = irq_en_reg && (count >= CW'(thresh_reg));    // see RL20
endmodule : adc_sequencer_tagged_fifo
`default_nettype wire

// File: hw/sample_fifo.sv
// Flip-flop FIFO holding tagged samples; drops pushes while full
`timescale 1ns/1ps
`default_nettype none
module sample_fifo
    import adc_seq_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH,
    parameter int CW    = $clog2(DEPTH + 1)
) (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    input  wire logic        i_ce,
    // Write side
    input  wire logic        i_push,
    input  wire fifo_entry_t i_push_data,
    // Read side
    input  wire logic        i_pop,
    output fifo_entry_t      o_head,
    // Status
    output logic             o_empty,
    output logic             o_full,
    output logic [CW-1:0]    o_count
);
    localparam int AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || CW < $clog2(DEPTH + 1)) begin
            $error("bad fifo depth");
        end
    end

    fifo_entry_t       mem [DEPTH];
    logic [AW-1:0]     wr_ptr_reg;
    logic [AW-1:0]     rd_ptr_reg;
    logic [CW-1:0]     count_reg;
    logic              do_push;
    logic              do_pop;

    assign o_empty = (count_reg == '0);
    assign o_full  = (count_reg == CW'(DEPTH));
    assign o_count = count_reg;
    assign o_head  = mem[rd_ptr_reg];
    assign do_push = i_push && !o_full;
    assign do_pop  = i_pop && !o_empty;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
    endfunction : bump

    always_ff @(posedge i_clk) begin
        if (i_ce && do_push) begin
            mem[wr_ptr_reg] <= i_push_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else if (i_ce) begin
            if (do_push) begin
                wr_ptr_reg <= bump(wr_ptr_reg);
            end
            if (do_pop) begin
                rd_ptr_reg <= bump(rd_ptr_reg);
            end
            if (do_push && !do_pop) begin
                count_reg <= CW'(count_reg + 1'b1);
            end else if (do_pop && !do_push) begin
                count_reg <= CW'(count_reg - 1'b1);
            end
        end
    end
endmodule : sample_fifo
`default_nettype wire

// File: verif/adc_pair_model.sv
// Model of the two converters
`timescale 1ns/1ps
`default_nettype none
module adc_pair_model (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    // Conversion request
    input  wire logic        i_conv_start,
    input  wire logic [2:0]  i_conv_chan,
    // Scenario settings
    input  wire logic [15:0] i_base,
    input  wire logic [3:0]  i_delay,
    // Results
    output logic             o_valid,
    output logic [15:0]      o_data_a,
    output logic [15:0]      o_data_b
);
    logic [3:0]  wait_reg;
    logic [15:0] junk_reg;

    // Data lines churn outside the valid cycle
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wait_reg <= 4'h0;
            o_valid  <= 1'b0;
            junk_reg <= 16'hA5C3;
        end else begin
            junk_reg <= ~junk_reg ^ 16'h0101;
            o_valid  <= (wait_reg == 4'h1);
            if (i_conv_start) begin
                wait_reg <= (i_delay == 4'h0) ? 4'h1 : i_delay;
            end else if (wait_reg != 4'h0) begin
                wait_reg <= wait_reg - 4'h1;
            end
        end
    end
    assign o_data_a = o_valid ? i_base ^ {13'h0, i_conv_chan} : junk_reg;
    assign o_data_b = o_valid ? ~i_base ^ {12'h0, 1'b1, i_conv_chan} : ~junk_reg;
endmodule : adc_pair_model
`default_nettype wire

// File: verif/adc_seq_properties.sv
// Concurrent checks on the sequencer's ports
`timescale 1ns/1ps
`default_nettype none
module adc_seq_properties
    import adc_seq_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    // Register port
    input  wire logic        i_ce,
    input  wire logic        i_reg_rd,
    input  wire logic [15:0] i_reg_addr,
    input  wire logic [31:0] o_reg_rdata,
    // Converter and trigger pins
    input  wire logic        o_conv_start,
    input  wire logic [2:0]  o_conv_chan,
    input  wire logic        o_trig,
    input  wire logic        o_trig_oe_b
);
    logic [9:0] gap_reg;
    logic [2:0] last_chan_reg;

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    // Cycles since last start
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            gap_reg       <= 10'h3FF;
            last_chan_reg <= 3'h7;
        end else if (o_conv_start) begin
            gap_reg       <= 10'h001;
            last_chan_reg <= o_conv_chan;
        end else if (gap_reg != 10'h3FF) begin
            gap_reg <= gap_reg + 10'h001;
        end
    end

    start_pulse_a: assert property (o_conv_start |=> !o_conv_start)
        else $error("start too long");
    chan_hold_a: assert property (o_conv_start |=> $stable(o_conv_chan) [*4])
        else $error("step moved");
    chan_order_a: assert property (
        o_conv_start |-> o_conv_chan == 3'(last_chan_reg + 3'h1))
        else $error("step order");
    start_space_a: assert property (o_conv_start |-> gap_reg >= 10'd50)
        else $error("starts too close");
    trig_drive_a: assert property (o_trig |-> !o_trig_oe_b)
        else $error("trigger undriven");
    trig_pulse_a: assert property (o_trig |=> !o_trig)
        else $error("trigger too long");
    fifo_word_a: assert property (
        i_ce && i_reg_rd && i_reg_addr == OFS_FIFO |=> o_reg_rdata[31:20] == 12'h000)
        else $error("upper bits set");
    start_wo_a: assert property (
        i_ce && i_reg_rd && i_reg_addr == OFS_START |=> o_reg_rdata == 32'h0000_0000)
        else $error("start reads nonzero");
    empty_flag_a: assert property (
        i_ce && i_reg_rd && i_reg_addr == OFS_CTRL
        |=> o_reg_rdata[CTRL_EMPTY] == (o_reg_rdata[31:16] == 16'h0000))
        else $error("empty flag wrong");
    full_flag_a: assert property (
        i_ce && i_reg_rd && i_reg_addr == OFS_CTRL
        |=> o_reg_rdata[CTRL_FULL] == (o_reg_rdata[31:16] == 16'(DEPTH)))
        else $error("full flag wrong");

    cover property (o_conv_start && o_conv_chan == 3'h7);
    cover property (o_trig);
    cover property (i_reg_rd && i_reg_addr == OFS_FIFO);
endmodule : adc_seq_properties
`default_nettype wire

// File: verif/adc_sequencer_tagged_fifo_tb.sv
// Self-checking bench for the converter sequencer and tagged FIFO
`timescale 1ns/1ps
`default_nettype none
`define CHECK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; \
    $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module adc_sequencer_tagged_fifo_tb;
    import adc_seq_pkg::*;
    localparam int DEPTH = FIFO_DEPTH;
    logic        i_clk = 1'b0, i_rst_b = 1'b0, i_ce = 1'b1, i_trig = 1'b0;
    logic        i_reg_wr = 1'b0, i_reg_rd = 1'b0, rd_note = 1'b0, rd_seen = 1'b0;
    logic [15:0] i_reg_addr = 16'h0000, base = 16'h0000, gain_a, gain_b, off_a, off_b;
    logic [31:0] i_reg_wdata = 32'h0, o_reg_rdata, v = 32'h0, e, seed = 32'h523D8CB6;
    logic [23:0] rl, rh;
    logic [3:0]  dly = 4'h1;
    logic [2:0]  o_conv_chan;
    logic [15:0] data_a, data_b;
    logic        o_conv_start, adc_valid, o_trig, o_trig_oe_b, o_irq;
    logic [31:0] q[$];
    int          fail_count = 0, checked = 0, n_start = 0, n_trig = 0, cyc = 0;
    int          gap = 0, last = 0, s0, n;

    always #12.5 i_clk = ~i_clk;

    adc_sequencer_tagged_fifo #(.DEPTH(DEPTH)) uut (.i_clk, .i_rst_b, .i_ce, .i_reg_wr,
        .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .o_conv_start, .o_conv_chan,
        .i_adc_valid(adc_valid), .i_adc_data_a(data_a), .i_adc_data_b(data_b), .i_trig,
        .o_trig, .o_trig_oe_b, .o_irq);
    adc_pair_model adcs (.i_clk, .i_rst_b, .i_conv_start(o_conv_start),
        .i_conv_chan(o_conv_chan), .i_base(base), .i_delay(dly), .o_valid(adc_valid),
        .o_data_a(data_a), .o_data_b(data_b));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    function automatic logic [31:0] exp_word(input logic [2:0] idx, input logic side);
        logic [15:0] d;
        logic [31:0] p;
        d = side ? ~base ^ {12'h0, 1'b1, idx} : base ^ {13'h0, idx};
        p = d * (side ? gain_b : gain_a);
        return {12'h000, side, idx, p[30:15] + (side ? off_b : off_a)};
    endfunction : exp_word

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_reg_wr <= 1'b1;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_clk);
        i_reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [31:0] x, input logic c);
        if (c) q.push_back(x);
        @(posedge i_clk);
        i_reg_rd <= 1'b1;
        i_reg_addr <= a;
        rd_note <= c;
        @(posedge i_clk);
        i_reg_rd <= 1'b0;
        @(negedge i_clk);
        v = o_reg_rdata;
    endtask : rd

    task automatic read_seq(input int cnt);
        for (int k = 0; k < cnt; k++) rd(OFS_FIFO, exp_word(3'(k >> 1), k[0]), 1'b1);
    endtask : read_seq

    task automatic wait_idle();
        int quiet = 0;
        int t = 0;
        while (quiet < 200 && t < 40000) begin
            @(posedge i_clk);
            t++;
            quiet = o_conv_start ? 0 : quiet + 1;
        end
        `CHECK(t < 40000, 1'b1)
    endtask : wait_idle

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : final_report

    always @(posedge i_clk) begin
        cyc++;
        rd_seen <= i_reg_rd && rd_note;
        if (o_trig) n_trig++;
        if (o_conv_start) begin
            n_start++;
            gap = cyc - last;
            last = cyc;
        end
    end

    always @(negedge i_clk) begin
        if (rd_seen) begin
            e = q.pop_front();
            `CHECK(o_reg_rdata, e)
        end
    end

    initial begin
        repeat (90000) @(posedge i_clk);
        fail_count++;
        final_report();
    end

    logic [15:0] ra[10] = '{OFS_CTRL, OFS_RANGE_LO, OFS_RANGE_HI, OFS_TIMER, OFS_THRESH,
        OFS_START, OFS_GAIN_A, OFS_GAIN_B, OFS_OFFSET_A, 16'hFFFC};
    logic [31:0] rv[10] = '{32'h100, 32'h0, 32'h0, 32'h0, 32'h3FF, 32'h0, 32'h8000,
        32'h8000, 32'h0, 32'h0};

    initial begin
        gain_a = GAIN_UNITY;
        gain_b = GAIN_UNITY;
        off_a = 16'h0000;
        off_b = 16'h0000;
        repeat (16) @(posedge i_clk);
        i_rst_b <= 1'b1;
        for (int i = 0; i < 10; i++) rd(ra[i], rv[i], 1'b1);
        $display("test reset values done");
        // Continuous until full
        base = 16'(rnd());
        dly = 4'(rnd());
        wr(OFS_RANGE_LO, 32'h00FF_FFFF);
        wr(OFS_RANGE_HI, 32'h00FF_FFFF);
        wr(OFS_THRESH, 32'd16);
        wr(OFS_CTRL, 32'h32);
        wr(OFS_START, 32'h1);
        `CHECK(o_trig_oe_b, 1'b0)
        for (n = 0; n < 1000 && v[CTRL_FULL] !== 1'b1; n++) begin
            repeat (50) @(posedge i_clk);
            rd(OFS_CTRL, 32'h0, 1'b0);
        end
        `CHECK(o_irq, 1'b1)
        repeat (300) @(posedge i_clk);
        wr(OFS_CTRL, 32'h30);
        wait_idle();
        `CHECK(n_start % 8, 0)
        `CHECK(n_trig * 8, n_start)
        rd(OFS_CTRL, {16'(DEPTH), 16'h0230}, 1'b1);
        read_seq(DEPTH);
        `CHECK(o_irq, 1'b0)
        rd(OFS_FIFO, 32'h0, 1'b1);
        rd(OFS_CTRL, 32'h0000_0130, 1'b1);
        $display("test continuous fill done");
        // Single, software start, some channels off
        base = 16'(rnd());
        rl = 24'(rnd()) & 24'hFFF1F8;
        rh = 24'(rnd()) & 24'h1FFFFF;
        wr(OFS_RANGE_LO, {8'h00, rl});
        wr(OFS_RANGE_HI, {8'h00, rh});
        wr(OFS_CTRL, 32'h1);
        s0 = n_start;
        wr(OFS_START, 32'h1);
        wait_idle();
        `CHECK(n_start - s0, 8)
        for (int i = 0; i < 16; i++) begin
            if ((i[0] ? rh[3*(i>>1)+:3] : rl[3*(i>>1)+:3]) != RANGE_OFF)
                rd(OFS_FIFO, exp_word(3'(i >> 1), i[0]), 1'b1);
        end
        rd(OFS_CTRL, 32'h0000_0101, 1'b1);
        $display("test single software start done");
        // Single, trigger pin, corrected
        base = 16'(rnd()) & 16'h7FFF;
        dly = 4'(rnd());
        gain_a = 16'h4000;
        off_b = 16'h0100;
        wr(OFS_GAIN_A, {16'h0, gain_a});
        wr(OFS_OFFSET_B, {16'h0, off_b});
        wr(OFS_TIMER, 32'd124);
        wr(OFS_RANGE_LO, 32'h00FF_FFFF);
        wr(OFS_RANGE_HI, 32'h00FF_FFFF);
        s0 = n_start;
        i_trig <= 1'b1;
        repeat (4) @(posedge i_clk);
        i_trig <= 1'b0;
        wait_idle();
        `CHECK(n_start - s0, 8)
        `CHECK(gap >= 79 && gap <= 81, 1'b1)
        read_seq(16);
        $display("test trigger with correction done");
        final_report();
    end
endmodule : adc_sequencer_tagged_fifo_tb

bind adc_sequencer_tagged_fifo adc_seq_properties #(.DEPTH(DEPTH)) u_props (.i_clk, .i_rst_b,
    .i_ce, .i_reg_rd, .i_reg_addr, .o_reg_rdata, .o_conv_start, .o_conv_chan, .o_trig,
    .o_trig_oe_b);
`default_nettype wire
